// ### design/dsj_exec.sv
`timescale 1ns/1ps
`default_nettype none
module dsj_exec
  import dsj_pkg::*;
(
  input wire logic clk,
  input wire logic arst_n,
  input wire logic [15:0] instr_word,
  input wire logic [15:0] next_word,
  input wire logic next_is_two_word,
  input wire logic [7:0] file_rdata,
  output logic [1:0] quarter,
  output logic file_rd,
  output logic [7:0] file_addr,
  output logic bank_sel,
  output logic [7:0] result,
  output logic file_we,
  output logic wreg_we,
  output logic pc_load,
  output logic [DSJ_PC_W-1:0] program_counter,
  output logic flush,
  output logic busy
);
  dsj_state_e state;
  logic cycle_end;
  logic [7:0] opnd;
  logic [7:0] tgt_low;
  logic is_jump;
  logic is_dsz;
  logic is_dsnz;
  logic skip;

  dsj_quarter u_quarter (
    .clk(clk),
    .arst_n(arst_n),
    .quarter(quarter),
    .cycle_end(cycle_end)
  );

  ////////////////////////////////////////////////////////////////////////////
  // decode only meaningful while executing
  assign is_jump = (state == DSJ_EXEC) && (instr_word[15:8] == DSJ_OP_JUMP);
  assign is_dsz = (state == DSJ_EXEC) && (instr_word[15:10] == DSJ_OP_DSZ);
  assign is_dsnz = (state == DSJ_EXEC) && (instr_word[15:10] == DSJ_OP_DSNZ);
  // result is zero exactly when the operand was one; avoids a wide compare
  assign skip = (is_dsz && (opnd == DSJ_ONE)) || (is_dsnz && (opnd != DSJ_ONE));
  assign busy = (state != DSJ_EXEC);

  ////////////////////////////////////////////////////////////////////////////
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      state <= DSJ_EXEC;
    end else if (cycle_end) begin
      case (state)
        DSJ_EXEC: begin
          if (is_jump) begin
            state <= DSJ_IDLE1;
          end else if (skip) begin
            state <= next_is_two_word ? DSJ_IDLE2 : DSJ_IDLE1;
          end else begin
            state <= DSJ_EXEC;
          end
        end
        DSJ_IDLE2: state <= DSJ_IDLE1;
        DSJ_IDLE1: state <= DSJ_EXEC;
        default: state <= DSJ_EXEC;
      endcase
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // file path: read in q2, compute in q3, write in q4
  always_comb begin
    file_rd = (is_dsz || is_dsnz) && (quarter == DSJ_Q2);
    file_we = (is_dsz || is_dsnz) && (quarter == DSJ_Q4) && instr_word[9];
    wreg_we = (is_dsz || is_dsnz) && (quarter == DSJ_Q4) && !instr_word[9];
  end
  assign file_addr = instr_word[7:0];
  assign bank_sel = instr_word[8];

  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      opnd <= DSJ_ZERO;
    end else if (file_rd) begin
      opnd <= file_rdata;
    end
  end

  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      result <= DSJ_ZERO;
    end else if ((is_dsz || is_dsnz) && quarter == DSJ_Q3) begin
      result <= opnd - DSJ_ONE;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      tgt_low <= DSJ_ZERO;
    end else if (is_jump && quarter == DSJ_Q2) begin
      tgt_low <= instr_word[7:0];
    end
  end

  // a second word without the ones prefix is not a jump; the load is suppressed
  assign pc_load = is_jump && (quarter == DSJ_Q4) && (next_word[15:12] == DSJ_OP_SECOND);

  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      program_counter <= '0;
    end else if (pc_load) begin
      // absolute load, bit 0 kept as is
      program_counter <= {next_word[11:0], tgt_low, program_counter[0]};
    end
  end

  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      flush <= 1'b0;
    end else begin
      flush <= cycle_end && state == DSJ_EXEC && (is_jump || skip);
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  jump_two_cycles_a: assert property (@(posedge clk) disable iff (!arst_n)
    pc_load |=> busy [*4] ##1 !busy) else $error("jump not two cycles");

  idle_no_write_a: assert property (@(posedge clk) disable iff (!arst_n)
    busy |-> !file_we && !wreg_we && !pc_load && !file_rd) else $error("idle did work");

  jump_pc_value_a: assert property (@(posedge clk) disable iff (!arst_n)
    pc_load |=> program_counter[20:13] == $past(next_word[11:4])) else $error("pc high");

  pc_bit0_keep_a: assert property (@(posedge clk) disable iff (!arst_n)
    pc_load |=> $stable(program_counter[0])) else $error("pc bit0 changed");

  dest_select_a: assert property (@(posedge clk) disable iff (!arst_n)
    !(file_we && wreg_we)) else $error("two destinations");

  read_then_write_a: assert property (@(posedge clk) disable iff (!arst_n)
    file_rd |-> ##2 (file_we || wreg_we)) else $error("no write after read");

  decrement_value_a: assert property (@(posedge clk) disable iff (!arst_n)
    file_rd |=> ##1 result == opnd - DSJ_ONE) else $error("bad decrement");

  skip_two_word_a: assert property (@(posedge clk) disable iff (!arst_n)
    (cycle_end && skip && next_is_two_word && !is_jump) |=> busy [*8])
    else $error("two-word skip short");

  zero_skip_a: assert property (@(posedge clk) disable iff (!arst_n)
    (cycle_end && is_dsz && opnd == DSJ_ONE) |=> flush) else $error("missed zero skip");

  ////////////////////////////////////////////////////////////////////////////
  // quarter and strobe placement
  quarter_wrap_a: assert property (@(posedge clk) disable iff (!arst_n)
    quarter == DSJ_Q4 |=> quarter == DSJ_Q1) else $error("quarter did not wrap");

  read_in_q2_a: assert property (@(posedge clk) disable iff (!arst_n)
    file_rd |-> quarter == DSJ_Q2) else $error("read outside q2");

  write_in_q4_a: assert property (@(posedge clk) disable iff (!arst_n)
    (file_we || wreg_we) |-> quarter == DSJ_Q4) else $error("write outside q4");

  jump_no_file_a: assert property (@(posedge clk) disable iff (!arst_n)
    is_jump |-> !file_rd && !file_we && !wreg_we) else $error("jump touched file");

  ////////////////////////////////////////////////////////////////////////////
  // program counter only moves on a jump load
  pc_only_jump_a: assert property (@(posedge clk) disable iff (!arst_n)
    $changed(program_counter) |-> $past(pc_load)) else $error("pc moved without jump");

  jump_low_byte_a: assert property (@(posedge clk) disable iff (!arst_n)
    pc_load |=> program_counter[8:1] == $past(instr_word[7:0]))
    else $error("pc low byte");

  jump_flush_a: assert property (@(posedge clk) disable iff (!arst_n)
    pc_load |=> flush) else $error("jump did not discard fetch");

  ////////////////////////////////////////////////////////////////////////////
  // skip timing; a refused second word still costs the idle cycle
  nonzero_skip_a: assert property (@(posedge clk) disable iff (!arst_n)
    (cycle_end && is_dsnz && opnd != DSJ_ONE) |=> flush) else $error("missed nonzero skip");

  flush_pulse_a: assert property (@(posedge clk) disable iff (!arst_n)
    flush |=> !flush) else $error("flush longer than one clock");

  skip_one_word_a: assert property (@(posedge clk) disable iff (!arst_n)
    (cycle_end && skip && !next_is_two_word && !is_jump) |=> busy [*4] ##1 !busy)
    else $error("one-word skip length");

  no_skip_run_a: assert property (@(posedge clk) disable iff (!arst_n)
    (cycle_end && (is_dsz || is_dsnz) && !skip) |=> !busy) else $error("idle without skip");

  no_skip_flush_a: assert property (@(posedge clk) disable iff (!arst_n)
    (cycle_end && (is_dsz || is_dsnz) && !skip) |=> !flush) else $error("flush without skip");

  refused_jump_a: assert property (@(posedge clk) disable iff (!arst_n)
    (cycle_end && is_jump) |=> busy [*4] ##1 !busy) else $error("jump length");

  jump_cov_c: cover property (@(posedge clk) disable iff (!arst_n) pc_load);
  refused_cov_c: cover property (@(posedge clk) disable iff (!arst_n)
    cycle_end && is_jump && !pc_load);
  skip_cov_c: cover property (@(posedge clk) disable iff (!arst_n) cycle_end && skip);
  long_skip_c: cover property (@(posedge clk) disable iff (!arst_n)
    cycle_end && skip && next_is_two_word);
endmodule
`default_nettype wire

// ### shared/dsj_pkg.sv
`default_nettype none
package dsj_pkg;
  localparam int DSJ_PC_W = 21;
  localparam int DSJ_TGT_W = 20;
  localparam logic [7:0] DSJ_OP_JUMP = 8'hEF;
  localparam logic [3:0] DSJ_OP_SECOND = 4'hF;
  localparam logic [5:0] DSJ_OP_DSZ = 6'h0B;
  localparam logic [5:0] DSJ_OP_DSNZ = 6'h13;
  localparam logic [7:0] DSJ_ONE = 8'h01;
  localparam logic [7:0] DSJ_ZERO = 8'h00;
  localparam logic [1:0] DSJ_Q1 = 2'h0;
  localparam logic [1:0] DSJ_Q2 = 2'h1;
  localparam logic [1:0] DSJ_Q3 = 2'h2;
  localparam logic [1:0] DSJ_Q4 = 2'h3;
  typedef enum logic [1:0] {DSJ_EXEC, DSJ_IDLE1, DSJ_IDLE2} dsj_state_e;
endpackage
`default_nettype wire

// ### design/dsj_quarter.sv
`timescale 1ns/1ps
`default_nettype none
// free-running quarter-phase counter; one instruction cycle is four clocks
module dsj_quarter
  import dsj_pkg::*;
(
  input wire logic clk,
  input wire logic arst_n,
  output logic [1:0] quarter,
  output logic cycle_end
);
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      quarter <= DSJ_Q1;
    end else begin
      quarter <= quarter + 2'h1;
    end
  end
  assign cycle_end = (quarter == DSJ_Q4);
endmodule
`default_nettype wire

// ### sim/decrement_skip_and_jump_exec_tb.sv
`timescale 1ns/1ps
`default_nettype none
module decrement_skip_and_jump_exec_tb
  import dsj_pkg::*;
;
  logic clk = 1'b0;
  logic arst_n = 1'b0;
  logic [15:0] instr_word = 16'h0000;
  logic [15:0] next_word = 16'h0000;
  logic next_is_two_word = 1'b0;
  logic [7:0] file_rdata = 8'h00;
  logic [1:0] quarter;
  logic file_rd, bank_sel, file_we, wreg_we, pc_load, flush, busy;
  logic [7:0] file_addr, result;
  logic [DSJ_PC_W-1:0] program_counter;
  logic s_rd, s_ld, s_fwe, s_wwe, s_bsel;
  logic [7:0] s_addr;
  int mismatches = 0;
  int n_tests = 0;
  always #20 clk = ~clk;
  dsj_exec dut (.clk(clk), .arst_n(arst_n), .instr_word(instr_word), .next_word(next_word),
    .next_is_two_word(next_is_two_word), .file_rdata(file_rdata), .quarter(quarter),
    .file_rd(file_rd), .file_addr(file_addr), .bank_sel(bank_sel), .result(result),
    .file_we(file_we), .wreg_we(wreg_we), .pc_load(pc_load),
    .program_counter(program_counter), .flush(flush), .busy(busy));
////////////////////////////////////////////////////////////////////////////////
  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    n_tests++;
    if (seen !== exp) begin
      mismatches++;
      $display("mismatch at %0t: saw %h want %h", $time, seen, exp);
    end
  endtask
  task automatic print_verdict();
    $display("mismatches %0d n_tests %0d", mismatches, n_tests);
    if (mismatches == 0 && n_tests > 0) begin
      $display("No errors found");
    end else begin
      $display("Errors were found");
    end
    $finish;
  endtask
  // one executing cycle, then the no-op cycles that must follow
  task automatic run(input logic [15:0] iw, input logic [15:0] nw, input logic two,
      input logic [7:0] rd, input int idle);
    // first call after reset: the quarter counter runs free, so line up on q4
    while (quarter != DSJ_Q4) @(negedge clk);
    @(posedge clk);
    instr_word <= iw;
    next_word <= nw;
    next_is_two_word <= two;
    file_rdata <= rd;
    for (int q = 0; q < 4; q++) begin
      @(negedge clk);
      chk(quarter, q);
      chk(busy, 1'b0);
      if (q == 1) begin
        s_rd = file_rd;
        s_addr = file_addr;
        s_bsel = bank_sel;
      end
      if (q == 3) begin
        s_ld = pc_load;
        s_fwe = file_we;
        s_wwe = wreg_we;
      end
    end
    for (int k = 0; k < 4 * idle; k++) begin
      @(negedge clk);
      chk(busy, 1'b1);
      chk(flush, k == 0);
    end
  endtask
////////////////////////////////////////////////////////////////////////////////
  task automatic jump_far();
    run(16'hEF34, 16'hF123, 1'b0, 8'h00, 1);
    chk(s_ld, 1'b1);
    chk(program_counter, {20'h12334, 1'h0});
    run(16'hEFFF, 16'hFFFF, 1'b1, 8'h00, 1);
    chk(program_counter, {20'hFFFFF, 1'h0});
    // bad second word: still two cycles, no load
    run(16'hEF00, 16'h0AAA, 1'b0, 8'h00, 1);
    chk(s_ld, 1'b0);
    chk(program_counter, {20'hFFFFF, 1'h0});
  endtask
  task automatic dec_zero();
    run({DSJ_OP_DSZ, 2'h3, 8'h5A}, 16'h0000, 1'b0, 8'h01, 1);
    chk(s_rd, 1'b1);
    chk(s_addr, 8'h5A);
    chk(s_bsel, 1'b1);
    chk({s_fwe, s_wwe}, 2'h2);
    chk(result, 8'h00);
    run({DSJ_OP_DSZ, 2'h0, 8'h11}, 16'h0000, 1'b1, 8'h05, 0);
    chk({s_fwe, s_wwe, s_bsel}, 3'h2);
    chk(result, 8'h04);
  endtask
  task automatic dec_nonzero();
    run({DSJ_OP_DSNZ, 2'h1, 8'hC3}, 16'h0000, 1'b1, 8'h00, 2);
    chk(result, 8'hFF);
    chk({s_fwe, s_wwe}, 2'h1);
    run({DSJ_OP_DSNZ, 2'h2, 8'h07}, 16'h0000, 1'b1, 8'h01, 0);
    chk(result, 8'h00);
  endtask
////////////////////////////////////////////////////////////////////////////////
  initial begin
    repeat (10) @(posedge clk);
    arst_n <= 1'b1;
    jump_far();
    dec_zero();
    dec_nonzero();
    print_verdict();
  end
  // tests need under 100 clocks; generous margin
  initial begin
    #20000;
    mismatches++;
    print_verdict();
  end
endmodule
`default_nettype wire
